// [rtl/sram_core.sv]
// Notes on behaviour
// - Selected only with pipeline select low, high select high, low select low.
// - Full write by global write low, or byte enable and all lane strobes low.
// - After a write, outputs stay high impedance until a new strobed read.
// - Leaving sleep, outputs are high impedance until a new read drives them.
// - Output enable high forces outputs off at once, clock-independent.
// - On a write or deselect strobe, outputs release at the edge that samples it.
`default_nettype none
module sram_core
    import sram_pkg::*;
(
    input wire logic clock, // bus clock, rising edge
    input wire logic rst, // synchronous reset, active high
    input wire logic [ADDR_W-1:0] address, // word address
    input wire logic address_pipeline_select_n, // select, active low
    input wire logic depth_select_high, // depth select, active high
    input wire logic depth_select_low_n, // depth select, active low
    input wire logic processor_addr_strobe_n, // processor strobe, active low
    input wire logic controller_addr_strobe_n, // controller strobe, active low
    input wire logic global_write_n, // write all lanes, active low
    input wire logic byte_write_enable_n, // lane writes enable, active low
    input wire logic [LANES-1:0] byte_lane_write_n, // lane strobes, active low
    input wire logic output_enable_n, // output enable, asynchronous
    input wire logic sleep_request, // sleep input, asynchronous
    input wire logic [DATA_W-1:0] dq_in, // data bus level
    output logic [DATA_W-1:0] dq_out, // data driven on reads
    output logic dq_oe // high while driving data bus
);
    sram_ctrl_if ctrl ();
    core_state_t state;
    core_state_t next_state;
    logic [DATA_W-1:0] mem [MEM_DEPTH];
    logic [MEM_ADDR_W-1:0] word;
    logic access_ok;

    sram_select_decode decode
    (
        .clock(clock),
        .rst(rst),
        .address_pipeline_select_n(address_pipeline_select_n),
        .depth_select_high(depth_select_high),
        .depth_select_low_n(depth_select_low_n),
        .processor_addr_strobe_n(processor_addr_strobe_n),
        .controller_addr_strobe_n(controller_addr_strobe_n),
        .global_write_n(global_write_n),
        .byte_write_enable_n(byte_write_enable_n),
        .byte_lane_write_n(byte_lane_write_n),
        .ctrl(ctrl)
    );

    // modelled array uses the low address bits
    assign word = address[MEM_ADDR_W-1:0];
    // no access is taken while asleep
    // a strobe that races the sleep input cannot corrupt a stored word
    assign access_ok = !sleep_request;

    // next driver mode and read data
    always_comb
    begin
        next_state = state;
        if (sleep_request)
        begin
            next_state.mode = MODE_QUIET;
        end
        else if (ctrl.write_start)
        begin
            next_state.mode = MODE_QUIET;
        end
        else if (ctrl.deselect_start)
        begin
            next_state.mode = MODE_QUIET;
        end
        else if (ctrl.read_start)
        begin
            next_state.mode = MODE_DRIVE;
            next_state.dout = mem[word];
        end
    end

    // state register
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state.mode <= MODE_QUIET;
            state.dout <= DOUT_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    // lane-masked write into the array, sampled on the edge
    always_ff @(posedge clock)
    begin
        if (!rst && access_ok && ctrl.write_start)
        begin
            mem[word] <= (mem[word] & ~lane_bits(ctrl.lane_write)) | (dq_in & lane_bits(ctrl.lane_write));
        end
    end

    // output enable and sleep gate the driver without the clock
    // kept combinational so the release never waits for an edge
    assign dq_out = state.dout;
    assign dq_oe = (state.mode == MODE_DRIVE) && !output_enable_n && !sleep_request;

    a_deselect_quiet: assert property (@(posedge clock) disable iff (rst)
        (!sleep_request && ctrl.strobe
         && (address_pipeline_select_n || !depth_select_high || depth_select_low_n))
        |=> state.mode == MODE_QUIET)
        else $error("deselect did not quiet the bus");
    a_write_quiet: assert property (@(posedge clock) disable iff (rst)
        ctrl.write_start |=> !dq_oe)
        else $error("bus driven right after a write");
    a_quiet_holds: assert property (@(posedge clock) disable iff (rst)
        (state.mode == MODE_QUIET && !ctrl.read_start) |=> state.mode == MODE_QUIET)
        else $error("bus left quiet without a read");
    a_read_drives: assert property (@(posedge clock) disable iff (rst)
        (ctrl.read_start && !sleep_request) |=> state.mode == MODE_DRIVE && dq_out == $past(mem[word]))
        else $error("read did not present array data");
    a_sleep_exit: assert property (@(posedge clock) disable iff (rst)
        $fell(sleep_request) |-> state.mode == MODE_QUIET)
        else $error("bus not quiet on sleep exit");
    a_oe_off: assert property (@(posedge clock) disable iff (rst)
        (output_enable_n || sleep_request) |-> !dq_oe)
        else $error("driving with output enable high");
    a_release_turn: assert property (@(posedge clock) disable iff (rst)
        (dq_oe && (ctrl.write_start || ctrl.deselect_start)) |=> !dq_oe)
        else $error("driver not released at ownership change");
    a_drive_cause: assert property (@(posedge clock) disable iff (rst)
        ($rose(dq_oe) && $stable(output_enable_n) && $stable(sleep_request))
        |-> $past(ctrl.read_start))
        else $error("bus driven without a read");

    // a read only starts from a selected strobe
    a_drive_select: assert property (@(posedge clock) disable iff (rst)
        (state.mode == MODE_DRIVE && $past(state.mode) == MODE_QUIET)
        |-> $past(ctrl.selected && ctrl.strobe))
        else $error("driver enabled without a selected strobe");

    // a full-width write stores the whole bus word
    a_full_lands: assert property (@(posedge clock) disable iff (rst)
        (ctrl.write_start && !sleep_request && ctrl.lane_write == ALL_LANES)
        |=> mem[$past(word)] == $past(dq_in))
        else $error("full write did not store the bus word");

    // writes and deselects leave the held read word alone
    a_dout_stands: assert property (@(posedge clock) disable iff (rst)
        (ctrl.write_start || ctrl.deselect_start) |=> dq_out == $past(dq_out))
        else $error("read word changed on a write or deselect");

    // outside sleep, nothing moves without an address strobe
    a_idle_holds: assert property (@(posedge clock) disable iff (rst)
        (!ctrl.strobe && !sleep_request) |=> state == $past(state))
        else $error("state moved without an address strobe");

    // sleep always leaves the driver in quiet mode, reads included
    a_sleep_quiet: assert property (@(posedge clock) disable iff (rst)
        sleep_request |=> state.mode == MODE_QUIET)
        else $error("driver mode kept through sleep");
    a_sleep_read: assert property (@(posedge clock) disable iff (rst)
        (sleep_request && ctrl.read_start) |=> !dq_oe)
        else $error("read taken while asleep");

    // output enable low lets a held read word through
    a_oe_pass: assert property (@(posedge clock) disable iff (rst)
        (state.mode == MODE_DRIVE && !output_enable_n && !sleep_request) |-> dq_oe)
        else $error("read word held back with output enable low");
endmodule : sram_core
`default_nettype wire

// [rtl/sram_pkg.sv]
`default_nettype none
package sram_pkg;
    // data path: four byte lanes of nine bits
    localparam int DATA_W = 36;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    // address pins, and the depth of the array actually modelled
    localparam int ADDR_W = 21;
    localparam int MEM_ADDR_W = 6;
    localparam int MEM_DEPTH = 64;
    localparam logic [3:0] ALL_LANES = 4'hf;
    localparam logic [3:0] NO_LANES = 4'h0;
    localparam logic [DATA_W-1:0] DOUT_RESET = 36'h0;

    // output driver mode of the data bus
    typedef enum logic {MODE_QUIET, MODE_DRIVE} bus_mode_t;

    // registered state of the core
    typedef struct packed {
        bus_mode_t mode;
        logic [DATA_W-1:0] dout;
    } core_state_t;

    // expand a lane mask into a bit mask over the data word
    function automatic logic [DATA_W-1:0] lane_bits(input logic [LANES-1:0] lanes);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < LANES; i++)
        begin
            m[i*LANE_W +: LANE_W] = {LANE_W{lanes[i]}};
        end
        return m;
    endfunction : lane_bits
endpackage : sram_pkg
`default_nettype wire

// [rtl/sram_ctrl_if.sv]
`default_nettype none
interface sram_ctrl_if;
    logic selected;
    logic strobe;
    logic read_start;
    logic write_start;
    logic deselect_start;
    logic [3:0] lane_write;

    modport decode
    (
        output selected, strobe, read_start, write_start, deselect_start, lane_write
    );
    modport core
    (
        input selected, strobe, read_start, write_start, deselect_start, lane_write
    );
endinterface : sram_ctrl_if
`default_nettype wire

// [rtl/sram_select_decode.sv]
`default_nettype none
module sram_select_decode
    import sram_pkg::*;
(
    input wire logic clock, // bus clock
    input wire logic rst, // synchronous reset
    input wire logic address_pipeline_select_n, // select, active low
    input wire logic depth_select_high, // depth select, active high
    input wire logic depth_select_low_n, // depth select, active low
    input wire logic processor_addr_strobe_n, // processor strobe
    input wire logic controller_addr_strobe_n, // controller strobe
    input wire logic global_write_n, // write all lanes
    input wire logic byte_write_enable_n, // lane writes enable
    input wire logic [LANES-1:0] byte_lane_write_n, // per-lane write
    sram_ctrl_if.decode ctrl // decoded controls
);
    logic [LANES-1:0] lanes;

    // three-input chip select
    assign ctrl.selected = !address_pipeline_select_n && depth_select_high && !depth_select_low_n;
    assign ctrl.strobe = !processor_addr_strobe_n || !controller_addr_strobe_n;

    // global write covers every lane, else per-lane under enable
    always_comb
    begin
        lanes = NO_LANES;
        if (!global_write_n)
        begin
            lanes = ALL_LANES;
        end
        else if (!byte_write_enable_n)
        begin
            lanes = ~byte_lane_write_n;
        end
    end
    assign ctrl.lane_write = lanes;

    // access starts, taken only with a strobe
    assign ctrl.write_start = ctrl.strobe && ctrl.selected && (lanes != NO_LANES);
    assign ctrl.read_start = ctrl.strobe && ctrl.selected && (lanes == NO_LANES);
    assign ctrl.deselect_start = ctrl.strobe && !ctrl.selected;

    a_global_full: assert property (@(posedge clock) disable iff (rst)
        !global_write_n |-> ctrl.lane_write == ALL_LANES)
        else $error("global write did not select all lanes");
    a_lane_full: assert property (@(posedge clock) disable iff (rst)
        (global_write_n && !byte_write_enable_n && byte_lane_write_n == NO_LANES)
        |-> ctrl.lane_write == ALL_LANES && ctrl.write_start == (ctrl.strobe && ctrl.selected))
        else $error("lane writes did not form a full write");
endmodule : sram_select_decode
`default_nettype wire

// [bench/bus_master_model.sv]
`default_nettype none
module bus_master_model
    import sram_pkg::*;
(
    input wire logic clock, // bus clock
    input wire logic [DATA_W-1:0] dq_out, // device read data
    input wire logic dq_oe, // device drives bus
    output logic [DATA_W-1:0] dq_in, // resolved bus level
    output logic [ADDR_W-1:0] address, // word address
    output logic address_pipeline_select_n, // select
    output logic depth_select_high, // select
    output logic depth_select_low_n, // select
    output logic processor_addr_strobe_n, // strobe
    output logic controller_addr_strobe_n, // strobe
    output logic global_write_n, // all lanes
    output logic byte_write_enable_n, // lane enable
    output logic [LANES-1:0] byte_lane_write_n, // lanes
    output logic output_enable_n, // output enable
    output logic sleep_request // sleep input
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv = 1'b0;
    logic [DATA_W-1:0] wdata = '0;
    logic [DATA_W-1:0] last = '0;
    // a released bus shows the inverse of its last level
    assign dq_in = dq_oe ? dq_out : (drv ? wdata : ~last);
    always @(posedge clock) last <= dq_in;
    initial {address, depth_select_low_n, depth_select_high, address_pipeline_select_n} = {21'h0, 3'h5};
    initial {processor_addr_strobe_n, controller_addr_strobe_n, global_write_n, byte_write_enable_n} = 4'hf;
    initial {byte_lane_write_n, output_enable_n, sleep_request} = 6'h3c;
    // one strobed access; sel is {low_n, high, pipe_n}, w is {global, enable, lanes}
    // a write holds output enable high so the bus has a single driver
    task automatic access(input logic c, input logic [2:0] s, input logic [5:0] w, input logic [20:0] a,
        input logic [35:0] d);
        logic wr;
        logic oe_keep;
        wr = !(w[5] && (w[4] || &w[3:0]));
        @(posedge clock);
        oe_keep = output_enable_n;
        {processor_addr_strobe_n, controller_addr_strobe_n} <= c ? 2'b10 : 2'b01;
        {depth_select_low_n, depth_select_high, address_pipeline_select_n} <= s;
        {global_write_n, byte_write_enable_n, byte_lane_write_n} <= w;
        address <= a;
        wdata <= d;
        drv <= wr;
        output_enable_n <= wr ? 1'b1 : oe_keep;
        @(posedge clock);
        {processor_addr_strobe_n, controller_addr_strobe_n, global_write_n, byte_write_enable_n} <= 4'hf;
        byte_lane_write_n <= 4'hf;
        {depth_select_low_n, depth_select_high, address_pipeline_select_n} <= 3'h5;
        output_enable_n <= oe_keep;
        drv <= 1'b0;
    endtask : access
    // asynchronous controls, changed at an edge while deselected
    task automatic set_ctl(input logic o, input logic z);
        @(posedge clock);
        output_enable_n <= o;
        sleep_request <= z;
    endtask : set_ctl
endmodule : bus_master_model
`default_nettype wire

// [bench/tb_sram_core.sv]
`default_nettype none
module tb_sram_core
    import sram_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [DATA_W-1:0] dq_in, dq_out;
    logic [ADDR_W-1:0] address;
    logic [LANES-1:0] byte_lane_write_n;
    logic dq_oe, address_pipeline_select_n, depth_select_high, depth_select_low_n, processor_addr_strobe_n;
    logic controller_addr_strobe_n, global_write_n, byte_write_enable_n, output_enable_n, sleep_request;
    int error_cnt = 0;
    int samples_checked = 0;
    always #4 clock = ~clock;
    bus_master_model bm
    (
        .clock(clock),
        .dq_out(dq_out),
        .dq_oe(dq_oe),
        .dq_in(dq_in),
        .address(address),
        .address_pipeline_select_n(address_pipeline_select_n),
        .depth_select_high(depth_select_high),
        .depth_select_low_n(depth_select_low_n),
        .processor_addr_strobe_n(processor_addr_strobe_n),
        .controller_addr_strobe_n(controller_addr_strobe_n),
        .global_write_n(global_write_n),
        .byte_write_enable_n(byte_write_enable_n),
        .byte_lane_write_n(byte_lane_write_n),
        .output_enable_n(output_enable_n),
        .sleep_request(sleep_request)
    );
    sram_core uut
    (
        .clock(clock),
        .rst(rst),
        .address(address),
        .address_pipeline_select_n(address_pipeline_select_n),
        .depth_select_high(depth_select_high),
        .depth_select_low_n(depth_select_low_n),
        .processor_addr_strobe_n(processor_addr_strobe_n),
        .controller_addr_strobe_n(controller_addr_strobe_n),
        .global_write_n(global_write_n),
        .byte_write_enable_n(byte_write_enable_n),
        .byte_lane_write_n(byte_lane_write_n),
        .output_enable_n(output_enable_n),
        .sleep_request(sleep_request),
        .dq_in(dq_in),
        .dq_out(dq_out),
        .dq_oe(dq_oe)
    );
    // compare tasks
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // compare the driver flag
    task automatic chk_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_flag
    task automatic rd(input logic c, input logic [20:0] a);
        bm.access(c, 3'h2, 6'h3f, a, 36'h0);
        #1;
    endtask : rd
    // writes by each strobe kind, partial merge, read back
    task automatic t_write;
        bm.access(0, 3'h2, 6'h1f, 21'h5, 36'h9a5a5a5a5);
        #1 chk_flag(dq_oe, 1'b0);
        rd(0, 21'h5);
        chk_flag(dq_oe, 1'b1);
        chk(dq_out, 36'h9a5a5a5a5);
        bm.access(1, 3'h2, 6'h20, 21'h6, 36'h123456789);
        #1 chk_flag(dq_oe, 1'b0);
        bm.access(0, 3'h2, 6'h2e, 21'h6, 36'hfedcba0ff);
        #1 chk_flag(dq_oe, 1'b0);
        rd(1, 21'h6);
        chk_flag(dq_oe, 1'b1);
        chk(dq_out, 36'h1234566ff);
        $display("test write done");
    endtask : t_write
    // each select at its opposite level refuses the read
    task automatic t_desel;
        for (int i = 0; i < 3; i++)
        begin
            rd(0, 21'h5);
            bm.access(0, 3'h2 ^ (3'h1 << i), 6'h3f, 21'h5, 36'h0);
            #1 chk_flag(dq_oe, 1'b0);
        end
        $display("test deselect done");
    endtask : t_desel
    // output enable and sleep act at once; sleep exit stays quiet
    task automatic t_async;
        rd(0, 21'h5);
        bm.set_ctl(1, 0);
        #1 chk_flag(dq_oe, 1'b0);
        bm.set_ctl(0, 0);
        #1 chk_flag(dq_oe, 1'b1);
        bm.set_ctl(0, 1);
        #1 chk_flag(dq_oe, 1'b0);
        bm.set_ctl(0, 0);
        #1 chk_flag(dq_oe, 1'b0);
        repeat (3) @(posedge clock);
        #1 chk_flag(dq_oe, 1'b0);
        rd(1, 21'h5);
        chk_flag(dq_oe, 1'b1);
        chk(dq_out, 36'h9a5a5a5a5);
        $display("test async done");
    endtask : t_async
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    // main sequence after four cycles of reset
    initial
    begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        #1 chk_flag(dq_oe, 1'b0);
        t_write();
        t_desel();
        t_async();
        end_sim();
    end
    // watchdog
    initial
    begin
        #20000;
        error_cnt++;
        end_sim();
    end
endmodule : tb_sram_core
`default_nettype wire
